// ===== shared/pgc_cfg.svh
// register indices, field positions, reset values and counts of the pattern generator/checker control
`ifndef PGC_CFG_SVH
`define PGC_CFG_SVH
`define PGC_IDX_CTRL     14'h0619
`define PGC_IDX_LEN      14'h061A
`define PGC_IDX_GAP      14'h061B
`define PGC_IDX_TALLY    14'h061C
`define PGC_IDX_CMD      14'h001B
`define PGC_IDX_GSTAT    14'h0630
`define PGC_IDX_IRQ_ST   14'h0631
`define PGC_IDX_IRQ_CLR  14'h0632
`define PGC_IDX_IRQ_EN   14'h0633
`define PGC_B_GEN_ON     0
`define PGC_B_PRBS       1
`define PGC_B_CHK_EN     2
`define PGC_B_WRAP       3
`define PGC_F_GEN_SEL    6:4
`define PGC_F_CHK_SEL    10:8
`define PGC_B_SEND       12
`define PGC_B_SHORT      13
`define PGC_B_LOCK       0
`define PGC_B_LOCK_CLR   1
`define PGC_B_EV_DONE    0
`define PGC_B_EV_MAX     1
`define PGC_RST_CTRL     16'h0574
`define PGC_RST_LEN      16'h05DC
`define PGC_RST_GAP      8'h7D
`define PGC_LEN_LONG     16'h05EE
`define PGC_LEN_SHORT    16'h0040
`define PGC_CRC_BYTES    16'h0004
`define PGC_CNT_MAX      16'hFFFF
`define PGC_CRC_POLY     32'hEDB8_8320
`define PGC_CRC_INIT     32'hFFFF_FFFF
`define PGC_LFSR_SEED    15'h7FFF
`endif

// ===== shared/pgc_pkg.sv
// types of the pattern generator/checker control
package pgc_pkg;
   typedef enum logic [1:0] {GEN_IDLE, GEN_DATA, GEN_GAP} pgc_gen_state_type;
   typedef enum logic [2:0] {
      SEL_RGMII = 3'h0, SEL_SGMII = 3'h1, SEL_RMII = 3'h2, SEL_MII = 3'h3, SEL_CU = 3'h5
   } pgc_path_sel_type;
endpackage

// ===== hw/pgc_ctrl.sv
// pattern/CRC frame generator and checker byte tally control with APB registers
// Function
// - plain packet mode sends 1518-byte frames, or 64-byte frames when short select set.
// - CRC frame trigger starts incrementing-payload CRC frames only with generator on, PRBS clear.
// - trigger bit is write-one-to-set and clears itself when burst finished sets.
// - checker source select routes checker input; 110/111 reserved; reset 101.
// - generator destination select routes generator output; 110/111 reserved; reset 111.
// - single mode stops all checker counting once any counter reaches maximum.
// - continuous mode pulses at maximum and restarts the counter from zero.
// - PRBS select with generator on produces pseudo-random frames continuously.
// - PRBS select with generator off keeps the receive checker enabled.
// - PRBS clear with generator on produces non-pseudo-random frames.
// - PRBS select and generator both clear also disables the checker.
// - generator on bit enables the generator; resets to zero.
// - 16-bit length field sets length of PRBS and CRC burst frames.
// - 8-bit gap field sets inter-frame gap bytes; reset 0x7D.
// - 16-bit read-only byte tally counts checker bytes; saturates in single mode.
// - tally frozen for reading on write of bit 0 or bit 1 of command register.
// - bit 0 only freezes counters; bit 1 freezes then clears them.
// - burst finished sets once all requested CRC frames are sent.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "pgc_cfg.svh"

module pgc_ctrl
   import pgc_pkg::*;
#(
   parameter int BURST_FRAMES = 1
)(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic [4:0]  chk_byte_vld,
   input  wire logic        chk_other_max,
   output logic             chk_enable,
   output logic             chk_halt,
   output logic             cnt_lock,
   output logic             cnt_clear,
   output logic             cnt_wrap_pulse,
   output logic [4:0]       gen_route,
   output logic             gen_valid,
   output logic [7:0]       gen_data,
   output logic             gen_first,
   output logic             gen_last,
   output logic             gen_busy,
   output logic             pkt_done,
   output logic             irq
);

   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h00_0000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `PGC_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // reset release through two flops
   logic rs1_q, rs2_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end
   wire logic rst_n = rs2_q;

   logic        gen_on_q, prbs_q, chk_en_q, wrap_q, send_q, short_q;
   logic [2:0]  gen_sel_q, chk_sel_q;
   logic [15:0] len_q, live_q, tally_q, idx_q;
   logic [7:0]  gap_q, gap_cnt_q;
   logic [1:0]  st_q, ien_q;
   logic        done_q, burst_q, crc_frm_q;
   logic [31:0] crc_q;
   logic [14:0] lfsr_q;
   logic [31:0] burst_cnt_q;
   pgc_gen_state_type state_q;
   logic [15:0] frm_len_q;
   localparam logic [15:0] RST_CTRL = `PGC_RST_CTRL;

   // bus decode
   wire logic        wr_acc   = psel & penable & pwrite & clk_en;
   wire logic        rd_setup = psel & ~penable & ~pwrite & clk_en;
   wire logic [13:0] widx     = paddr[15:2];
   wire logic        s_ctrl   = (widx == `PGC_IDX_CTRL);
   wire logic        s_len    = (widx == `PGC_IDX_LEN);
   wire logic        s_gap    = (widx == `PGC_IDX_GAP);
   wire logic        s_tally  = (widx == `PGC_IDX_TALLY);
   wire logic        s_cmd    = (widx == `PGC_IDX_CMD);
   wire logic        s_gstat  = (widx == `PGC_IDX_GSTAT);
   wire logic        s_ist    = (widx == `PGC_IDX_IRQ_ST);
   wire logic        s_iclr   = (widx == `PGC_IDX_IRQ_CLR);
   wire logic        s_ien    = (widx == `PGC_IDX_IRQ_EN);
   wire logic        hit      = s_ctrl | s_len | s_gap | s_tally | s_cmd | s_gstat | s_ist | s_iclr | s_ien;
   wire logic        w_ctrl   = wr_acc & s_ctrl;
   wire logic        w_cmd    = wr_acc & s_cmd;
   wire logic        lock_cmd = w_cmd & (pwdata[`PGC_B_LOCK] | pwdata[`PGC_B_LOCK_CLR]);
   wire logic        clr_cmd  = w_cmd & pwdata[`PGC_B_LOCK_CLR];

   assign pready  = clk_en;
   assign pslverr = psel & penable & ~hit;

   // checker side
   assign chk_enable = chk_en_q & (gen_on_q | prbs_q);
   wire logic at_max = (live_q == `PGC_CNT_MAX);
   assign chk_halt = ~wrap_q & (at_max | chk_other_max);
   logic chk_pick;
   always_comb begin
      unique case (pgc_path_sel_type'(chk_sel_q))
         SEL_RGMII: chk_pick = chk_byte_vld[0];
         SEL_SGMII: chk_pick = chk_byte_vld[1];
         SEL_RMII:  chk_pick = chk_byte_vld[2];
         SEL_MII:   chk_pick = chk_byte_vld[3];
         SEL_CU:    chk_pick = chk_byte_vld[4];
         default:   chk_pick = 1'b0;
      endcase
   end
   wire logic byte_in = chk_enable & chk_pick & ~chk_halt;
   wire logic ev_max  = byte_in & (live_q == (`PGC_CNT_MAX - 16'h0001));

   logic [15:0] live_d;
   always_comb begin
      live_d = live_q;
      if (clr_cmd) begin
         live_d = 16'h0000;
      end else if (byte_in) begin
         live_d = at_max ? 16'h0000 : live_q + 16'h0001;
      end
   end

   // generator side
   always_comb begin
      unique case (pgc_path_sel_type'(gen_sel_q))
         SEL_RGMII: gen_route = 5'b00001;
         SEL_SGMII: gen_route = 5'b00010;
         SEL_RMII:  gen_route = 5'b00100;
         SEL_MII:   gen_route = 5'b01000;
         SEL_CU:    gen_route = 5'b10000;
         default:   gen_route = 5'b00000;
      endcase
   end

   wire logic        start_burst = ~prbs_q & send_q;
   // plain packet mode uses fixed sizes; PRBS and CRC bursts take the length field
   wire logic [15:0] plain_len = short_q ? `PGC_LEN_SHORT : `PGC_LEN_LONG;
   wire logic [15:0] new_len   = (prbs_q | start_burst) ? len_q : plain_len;
   // latched at frame start: a live length could leave idx past the end for 64k bytes
   wire logic [15:0] cur_len   = frm_len_q;
   wire logic        last_byte = (idx_q == cur_len - 16'h0001) | (cur_len == 16'h0000);
   wire logic [15:0] crc_ofs   = idx_q - (cur_len - `PGC_CRC_BYTES);
   wire logic        in_crc    = crc_frm_q & (idx_q >= cur_len - `PGC_CRC_BYTES) & (cur_len >= `PGC_CRC_BYTES);
   wire logic [31:0] crc_out   = ~crc_q;
   wire logic [31:0] crc_shift = crc_out >> {crc_ofs[1:0], 3'b000};
   wire logic [7:0]  pay_byte  = crc_frm_q ? idx_q[7:0] : lfsr_q[7:0];
   wire logic [7:0]  out_byte  = in_crc ? crc_shift[7:0] : pay_byte;
   wire logic        emit      = (state_q == GEN_DATA) & gen_on_q;
   wire logic        last_burst = burst_cnt_q == 32'(BURST_FRAMES - 1);
   wire logic        ev_done   = emit & last_byte & burst_q & last_burst;
   wire logic        send_ok   = w_ctrl & pwdata[`PGC_B_SEND] & gen_on_q & ~prbs_q;

   // interrupts: set wins over write-one clear
   wire logic [1:0] ev_vec = {ev_max, ev_done};
   wire logic [1:0] clr_vec = (wr_acc & s_iclr) ? pwdata[1:0] : 2'b00;
   assign irq = |(st_q & ien_q);

   // read data, captured in the setup cycle
   wire logic [15:0] rd_ctrl = {2'b00, short_q, send_q, 1'b0, chk_sel_q, 1'b0, gen_sel_q,
                                wrap_q, chk_en_q, prbs_q, gen_on_q};
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      if (s_ctrl)  rd_mux = rd_ctrl;
      if (s_len)   rd_mux = len_q;
      if (s_gap)   rd_mux = {8'h00, gap_q};
      if (s_tally) rd_mux = tally_q;
      if (s_gstat) rd_mux = {14'h0000, gen_busy, done_q};
      if (s_ist)   rd_mux = {14'h0000, st_q};
      if (s_ien)   rd_mux = {14'h0000, ien_q};
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= {16'h0000, rd_mux};
      end
   end

   // control registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         short_q   <= RST_CTRL[`PGC_B_SHORT];
         chk_sel_q <= RST_CTRL[`PGC_F_CHK_SEL];
         gen_sel_q <= RST_CTRL[`PGC_F_GEN_SEL];
         wrap_q    <= RST_CTRL[`PGC_B_WRAP];
         chk_en_q  <= RST_CTRL[`PGC_B_CHK_EN];
         prbs_q    <= RST_CTRL[`PGC_B_PRBS];
         gen_on_q  <= RST_CTRL[`PGC_B_GEN_ON];
         len_q     <= `PGC_RST_LEN;
         gap_q     <= `PGC_RST_GAP;
         ien_q     <= 2'b00;
      end else if (clk_en) begin
         if (w_ctrl) begin
            short_q   <= pwdata[`PGC_B_SHORT];
            chk_sel_q <= pwdata[`PGC_F_CHK_SEL];
            gen_sel_q <= pwdata[`PGC_F_GEN_SEL];
            wrap_q    <= pwdata[`PGC_B_WRAP];
            chk_en_q  <= pwdata[`PGC_B_CHK_EN];
            prbs_q    <= pwdata[`PGC_B_PRBS];
            gen_on_q  <= pwdata[`PGC_B_GEN_ON];
         end
         if (wr_acc & s_len) len_q <= pwdata[15:0];
         if (wr_acc & s_gap) gap_q <= pwdata[7:0];
         if (wr_acc & s_ien) ien_q <= pwdata[1:0];
      end
   end

   // counters, trigger and status flags
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         live_q         <= 16'h0000;
         tally_q        <= 16'h0000;
         cnt_lock       <= 1'b0;
         cnt_clear      <= 1'b0;
         cnt_wrap_pulse <= 1'b0;
         send_q         <= 1'b0;
         done_q         <= 1'b0;
         st_q           <= 2'b00;
      end else if (clk_en) begin
         live_q         <= live_d;
         if (lock_cmd) tally_q <= live_q;
         cnt_lock       <= lock_cmd;
         cnt_clear      <= clr_cmd;
         cnt_wrap_pulse <= byte_in & at_max & wrap_q;
         // a new trigger wins over the auto-clear of the same cycle
         if (send_ok) begin
            send_q <= 1'b1;
         end else if (ev_done) begin
            send_q <= 1'b0;
         end
         if (ev_done) begin
            done_q <= 1'b1;
         end else if (send_ok) begin
            done_q <= 1'b0;
         end
         st_q <= (st_q & ~clr_vec) | ev_vec;
      end
   end

   // frame generator
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= GEN_IDLE;
         idx_q       <= 16'h0000;
         frm_len_q   <= 16'h0000;
         gap_cnt_q   <= 8'h00;
         burst_q     <= 1'b0;
         crc_frm_q   <= 1'b0;
         crc_q       <= `PGC_CRC_INIT;
         lfsr_q      <= `PGC_LFSR_SEED;
         burst_cnt_q <= 32'h0000_0000;
         gen_valid   <= 1'b0;
         gen_data    <= 8'h00;
         gen_first   <= 1'b0;
         gen_last    <= 1'b0;
      end else if (clk_en) begin
         gen_valid <= emit;
         gen_first <= emit & (idx_q == 16'h0000);
         gen_last  <= emit & last_byte;
         if (emit) gen_data <= out_byte;
         unique case (state_q)
            GEN_IDLE: begin
               idx_q <= 16'h0000;
               crc_q <= `PGC_CRC_INIT;
               if (gen_on_q && new_len != 16'h0000) begin
                  state_q   <= GEN_DATA;
                  crc_frm_q <= ~prbs_q;
                  frm_len_q <= new_len;
                  burst_q   <= start_burst;
               end
            end
            GEN_DATA: begin
               if (!gen_on_q) begin
                  // switching off aborts the frame; the burst position is kept
                  state_q <= GEN_IDLE;
               end else begin
                  idx_q  <= idx_q + 16'h0001;
                  lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
                  if (!in_crc) crc_q <= crc_step(crc_q, pay_byte);
                  if (last_byte) begin
                     if (burst_q) burst_cnt_q <= last_burst ? 32'h0000_0000 : burst_cnt_q + 32'h0000_0001;
                     // the idle state is one gap byte itself, so 0 and 1 both give one
                     gap_cnt_q <= gap_q - 8'h01;
                     state_q   <= (gap_q > 8'h01) ? GEN_GAP : GEN_IDLE;
                  end
               end
            end
            GEN_GAP: begin
               gap_cnt_q <= gap_cnt_q - 8'h01;
               if (gap_cnt_q == 8'h01) state_q <= GEN_IDLE;
            end
            default: state_q <= GEN_IDLE;
         endcase
      end
   end

   assign gen_busy = (state_q != GEN_IDLE);
   assign pkt_done = done_q;

endmodule // pgc_ctrl

// ===== bench/pgc_ctrl_assertions.sv
// port checks of the pattern generator/checker control
`timescale 1ns/10ps
module pgc_ctrl_assertions (
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        cnt_lock,
   input wire logic        cnt_clear,
   input wire logic        cnt_wrap_pulse,
   input wire logic [4:0]  chk_byte_vld,
   input wire logic [4:0]  gen_route,
   input wire logic        gen_valid,
   input wire logic        gen_first,
   input wire logic        gen_last
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence lock_wr;
      psel && penable && pready && pwrite && paddr == 16'h006C && pwdata[1:0] != 2'b00;
   endsequence
   sequence frame_end;
      gen_valid && gen_last;
   endsequence
   lock_follow_a: assert property (lock_wr |=> cnt_lock)
      else $error("no lock pulse after command write");
   lock_cause_a: assert property (cnt_lock |-> $past(psel && penable && pwrite && paddr == 16'h006C))
      else $error("lock pulse without command write");
   clear_cause_a: assert property (cnt_clear |-> cnt_lock && $past(pwdata[1] && psel && penable))
      else $error("clear pulse without lock or bit one");
   route_hot_a: assert property ($onehot0(gen_route))
      else $error("generator drives more than one path");
   gap_after_a: assert property (frame_end |=> !gen_valid)
      else $error("no gap after frame");
   first_valid_a: assert property (gen_first |-> gen_valid)
      else $error("frame start without byte");
   last_valid_a: assert property (gen_last |-> gen_valid)
      else $error("frame end without byte");
   wrap_cause_a: assert property (cnt_wrap_pulse |-> $past(chk_byte_vld != 5'h00))
      else $error("wrap pulse without a counted byte");
endmodule // pgc_ctrl_assertions

// ===== bench/pgc_path_model.sv
// far-side data paths: checker byte strobes and sink of the generator stream
`timescale 1ns/10ps
`include "pgc_cfg.svh"
module pgc_path_model (
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic [4:0] mask,
   input  wire logic       gen_valid,
   input  wire logic       gen_first,
   input  wire logic       gen_last,
   input  wire logic [7:0] gen_data,
   output logic [4:0]      vld,
   output logic [31:0]     fcs,
   output logic [7:0]      b1,
   output int              frames,
   output int              last_len,
   output int              gap
);
   int n;
   int idle;
   logic [31:0] crc_r;
   logic [31:0] crc_v;
   function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h00_0000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `PGC_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
   initial begin
      vld = 5'h00;
      fcs = 32'h0000_0000;
      b1 = 8'h00;
      crc_r = `PGC_CRC_INIT;
      frames = 0;
      last_len = 0;
      gap = 0;
      n = 0;
      idle = 0;
   end
   // strobes drop to zero outside a burst, never left at the last mask
   always @(posedge ref_clk) begin
      vld <= run ? mask : 5'h00;
      idle <= gen_valid ? 0 : idle + 1;
      if (gen_valid) begin
         // running crc over bytes and fcs ends on the fixed residue for a sound frame
         crc_v = crc8(gen_first ? `PGC_CRC_INIT : crc_r, gen_data);
         crc_r <= crc_v;
         if (gen_last) fcs <= crc_v;
         if (!gen_first && n == 1) b1 <= gen_data;
         n <= gen_first ? 1 : n + 1;
         if (gen_first) gap <= idle;
         if (gen_last) last_len <= gen_first ? 1 : n + 1;
         if (gen_last) frames <= frames + 1;
      end
   end
endmodule // pgc_path_model

// ===== bench/pgc_ctrl_bench.sv
// self-checking bench of the pattern generator/checker control
`timescale 1ns/10ps
`include "pgc_cfg.svh"
module pgc_ctrl_bench;
   import pgc_pkg::*;
   localparam logic [15:0] A_CTRL = {`PGC_IDX_CTRL, 2'b00};
   localparam logic [15:0] A_LEN  = {`PGC_IDX_LEN, 2'b00};
   localparam logic [15:0] A_GAP  = {`PGC_IDX_GAP, 2'b00};
   localparam logic [15:0] A_TAL  = {`PGC_IDX_TALLY, 2'b00};
   localparam logic [15:0] A_CMD  = {`PGC_IDX_CMD, 2'b00};
   localparam logic [15:0] A_IST  = {`PGC_IDX_IRQ_ST, 2'b00};
   localparam logic [15:0] A_ICLR = {`PGC_IDX_IRQ_CLR, 2'b00};
   localparam logic [15:0] A_IEN  = {`PGC_IDX_IRQ_EN, 2'b00};
   localparam logic [31:0] FCS_OK = 32'hDEBB_20E3;
   logic        ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        other_max = 1'b0, run = 1'b0, re;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rq;
   logic [4:0]  mask = 5'h00, vld, gen_route;
   logic [7:0]  gen_data, b1;
   logic [31:0] fcs;
   logic        pready, pslverr, chk_enable, chk_halt, cnt_lock, cnt_clear, cnt_wrap_pulse;
   logic        gen_valid, gen_first, gen_last, gen_busy, pkt_done, irq;
   int          frames, last_len, gap, f, wraps = 0, mismatches = 0, n_tests = 0;
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (cnt_wrap_pulse === 1'b1) wraps++;
   pgc_ctrl u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .chk_byte_vld(vld), .chk_other_max(other_max), .chk_enable(chk_enable), .chk_halt(chk_halt),
      .cnt_lock(cnt_lock), .cnt_clear(cnt_clear), .cnt_wrap_pulse(cnt_wrap_pulse), .gen_route(gen_route),
      .gen_valid(gen_valid), .gen_data(gen_data), .gen_first(gen_first), .gen_last(gen_last),
      .gen_busy(gen_busy), .pkt_done(pkt_done), .irq(irq));
   pgc_path_model u_path (.ref_clk(ref_clk), .run(run), .mask(mask), .gen_valid(gen_valid),
      .gen_first(gen_first), .gen_last(gen_last), .gen_data(gen_data), .vld(vld), .fcs(fcs), .b1(b1),
      .frames(frames), .last_len(last_len), .gap(gap));
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // zero-wait slave, but the wait on pready stays open-ended
   task automatic apb(input logic w, input logic [15:0] a, d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 16'h0000);
      chk(n, e, rq);
   endtask
   task automatic stream(input logic [4:0] m, input int n);
      @(posedge ref_clk);
      mask <= m;
      run <= 1'b1;
      repeat (n) @(posedge ref_clk);
      run <= 1'b0;
      cyc(3);
   endtask
   task automatic waitf();
      f = frames;
      while (frames < f + 2) @(posedge ref_clk);
      cyc(1);
   endtask
   function automatic logic [15:0] cw(input logic [2:0] gs, cs, input logic [3:0] lo, input logic [1:0] hi);
      return {2'b00, hi, 1'b0, cs, 1'b0, gs, lo};
   endfunction
   function automatic logic [4:0] oh(input int s);
      return (s < 4) ? 5'h01 << s : ((s == 5) ? 5'h10 : 5'h00);
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #(95000 * 100);
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      cyc(3);
      chk("route", 5'h00, gen_route);
      chk("chk_enable", 1'b0, chk_enable);
      rdc("ctrl", A_CTRL, 32'h0000_0574);
      rdc("len", A_LEN, 32'h0000_05DC);
      rdc("gap", A_GAP, 32'h0000_007D);
      wr(A_TAL, 16'h1234);
      rdc("tally", A_TAL, 32'h0000_0000);
      apb(1'b0, 16'h0100, 16'h0000);
      chk("slverr", 1'b1, re);
      for (int s = 0; s < 8; s++) begin
         wr(A_CTRL, cw(3'(s), 3'h5, 4'h0, 2'h0));
         chk("gen_route", oh(s), gen_route);
      end
      for (int s = 0; s < 8; s++) begin
         wr(A_CTRL, cw(3'h7, 3'(s), 4'h6, 2'h0));
         chk("chk_enable", 1'b1, chk_enable);
         stream(oh(s), 10);
         stream(~oh(s), 5);
         wr(A_CMD, 16'h0002);
         rdc("tally", A_TAL, (oh(s) == 5'h00) ? 0 : 10);
      end
      wr(A_CTRL, cw(3'h7, 3'h5, 4'h4, 2'h0));
      chk("chk_enable", 1'b0, chk_enable);
      wr(A_CTRL, cw(3'h7, 3'h5, 4'h6, 2'h0));
      stream(5'h10, 5);
      wr(A_CMD, 16'h0001);
      stream(5'h10, 3);
      rdc("tally", A_TAL, 5);
      wr(A_CMD, 16'h0001);
      rdc("tally", A_TAL, 8);
      @(posedge ref_clk);
      other_max <= 1'b1;
      cyc(1);
      chk("halt", 1'b1, chk_halt);
      wr(A_CTRL, cw(3'h7, 3'h5, 4'hE, 2'h0));
      chk("halt", 1'b0, chk_halt);
      @(posedge ref_clk);
      other_max <= 1'b0;
      wr(A_CTRL, cw(3'h7, 3'h5, 4'h6, 2'h0));
      wr(A_CMD, 16'h0002);
      stream(5'h10, 65540);
      wr(A_CMD, 16'h0001);
      rdc("tally", A_TAL, 32'h0000_FFFF);
      chk("halt", 1'b1, chk_halt);
      wr(A_CTRL, cw(3'h7, 3'h5, 4'hE, 2'h0));
      stream(5'h10, 2);
      chk("wraps", 1, wraps);
      wr(A_CMD, 16'h0001);
      rdc("tally", A_TAL, 1);
      wr(A_GAP, 16'h0005);
      wr(A_CTRL, cw(3'h5, 3'h5, 4'h1, 2'h2));
      waitf();
      chk("short len", 64, last_len);
      chk("gap", 5, gap);
      wr(A_CTRL, cw(3'h5, 3'h5, 4'h1, 2'h0));
      waitf();
      chk("long len", 1518, last_len);
      chk("long fcs", FCS_OK, fcs);
      chk("long payload", 8'h01, b1);
      wr(A_LEN, 16'h0014);
      wr(A_CTRL, cw(3'h5, 3'h5, 4'h3, 2'h0));
      waitf();
      chk("prbs len", 20, last_len);
      wr(A_CTRL, cw(3'h5, 3'h5, 4'h3, 2'h1));
      rdc("send refused", A_CTRL, cw(3'h5, 3'h5, 4'h3, 2'h0));
      wr(A_CTRL, cw(3'h5, 3'h5, 4'h1, 2'h0));
      wr(A_CTRL, cw(3'h5, 3'h5, 4'h1, 2'h1));
      while (pkt_done !== 1'b1) @(posedge ref_clk);
      cyc(1);
      chk("burst len", 20, last_len);
      chk("burst fcs", FCS_OK, fcs);
      chk("burst payload", 8'h01, b1);
      rdc("send cleared", A_CTRL, cw(3'h5, 3'h5, 4'h1, 2'h0));
      chk("irq masked", 1'b0, irq);
      wr(A_IEN, 16'h0003);
      chk("irq", 1'b1, irq);
      rdc("irq status", A_IST, 32'h0000_0003);
      wr(A_ICLR, 16'h0003);
      chk("irq cleared", 1'b0, irq);
      wr(A_CTRL, cw(3'h5, 3'h5, 4'h0, 2'h0));
      cyc(20);
      chk("busy", 1'b0, gen_busy);
      f = frames;
      cyc(100);
      chk("frames", f, frames);
      print_verdict();
   end
endmodule // pgc_ctrl_bench
bind pgc_ctrl pgc_ctrl_assertions u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .cnt_lock(cnt_lock), .cnt_clear(cnt_clear),
   .cnt_wrap_pulse(cnt_wrap_pulse), .chk_byte_vld(chk_byte_vld), .gen_route(gen_route), .gen_valid(gen_valid),
   .gen_first(gen_first), .gen_last(gen_last));
